// ==== rtl/rcs_pkg.sv ====
// Purpose: shared constants and types of the reset cause block
// Assumes: one clock, hclk at 25 MHz; oscillator period equals hclk period
// Notes: register offsets are byte addresses of aligned 32-bit words
`default_nettype none
package rcs_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_FLAGS  = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQCTL = 8'h08;
	localparam logic [7:0] ADDR_OPTION = 8'h0c;
	localparam logic [7:0] ADDR_CFG    = 8'h10;
	localparam logic [7:0] ADDR_SEQ    = 8'h14;
	localparam logic [7:0] ADDR_NONE   = 8'hff;
	localparam int FLG_BOR       = 0;
	localparam int FLG_POR       = 1;
	localparam int FLG_AUX       = 2;
	localparam int STATUS_PWRDN  = 3;
	localparam int STATUS_TMO    = 4;
	localparam int IRQCTL_GLB_EN = 7;
	localparam int CFG_PUT_EN_N  = 0;
	localparam int CFG_BOREN   = 1;
	localparam int CFG_OSC_LSB = 2;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [2:0] FLG_RST      = 3'h4;
	localparam logic [7:0] STATUS_RST   = 8'h18;
	localparam logic [4:0] ST_HI_PWR    = 5'h03;
	localparam logic [4:0] ST_HI_MSLP   = 5'h02;
	localparam logic [4:0] ST_HI_WDT    = 5'h01;
	localparam logic [2:0] ST_BANK_RST  = 3'h0;
	localparam logic [6:0] IRQCTL_H_RST = 7'h00;
	localparam logic [7:0] IRQCTL_RST   = 8'h00;
	localparam logic [7:0] OPTION_RST   = 8'hff;
	localparam logic [7:0] CFG_RST      = 8'h00;
	localparam int PC_W = 13;
	localparam logic [PC_W-1:0] PC_RESET   = 13'h0000;
	localparam logic [PC_W-1:0] PC_IRQ_VEC = 13'h0004;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CNT_W            = 16;
	localparam int CLK_PERIOD_NS    = 40;
	localparam int CPU_START_MIN_NS = 5000;
	localparam int CPU_START_CYC    = (CPU_START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XST_PERIODS      = 1024;
	localparam int PWRT_NS          = 64000;
	localparam int PWRT_CYC         = (PWRT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] CPU_CNT  = CNT_W'(CPU_START_CYC);
	localparam logic [CNT_W-1:0] XST_CNT  = CNT_W'(XST_PERIODS);
	localparam logic [CNT_W-1:0] PWRT_CNT = CNT_W'(PWRT_CYC);
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {OSC_XTAL, OSC_RC, OSC_SEC, OSC_RSVD} rcs_osc_t;
	typedef enum logic [2:0] {
		SEQ_BOOT, SEQ_PWRT, SEQ_XST, SEQ_CPU, SEQ_REL, SEQ_RUN, SEQ_SLEEP
	} rcs_seq_t;
	typedef enum logic [2:0] {
		KIND_POR, KIND_BOR, KIND_PIN, KIND_PIN_SLP, KIND_WDT, KIND_WAKE_WDT,
		KIND_WAKE_IRQ
	} rcs_kind_t;
	typedef struct packed {
		logic por;
		logic bor;
		logic wdt;
		logic irq_wake;
		logic sleep;
	} rcs_evt_t;
	typedef struct packed {
		logic            hold;
		logic            pc_load;
		logic [PC_W-1:0] pc_value;
	} rcs_cpu_t;
	typedef struct packed {
		logic        pend;
		logic        write;
		logic [7:0]  addr;
		logic        ready;
		logic        resp;
		logic [31:0] rdata;
	} rcs_bus_t;
	typedef struct packed {
		logic             busy;
		logic             done;
		logic [CNT_W-1:0] cnt;
	} rcs_tmr_t;
	typedef struct packed {
		rcs_seq_t  seq;
		rcs_kind_t kind;
		logic      pin_low;
		logic [2:0] flags;
		logic [7:0] status;
		logic [7:0] irqctl;
		logic [7:0] option;
		logic [7:0] cfg;
		rcs_cpu_t  cpu;
	} rcs_top_t;
endpackage
`default_nettype wire

// ==== rtl/rcs_delay_timer.sv ====
// Purpose: down counter for start-up delays
// Assumes: load count is at least one
// Notes: done pulses count cycles after the load edge
`timescale 1ns/1ps
`default_nettype none
module rcs_delay_timer (
	// clock and reset
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	// control
	input  wire logic                      load,
	input  wire logic [rcs_pkg::CNT_W-1:0] count,
	// status
	output logic                           busy,
	output logic                           done
);
	import rcs_pkg::*;

	rcs_tmr_t st_reg;
	rcs_tmr_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (load) begin
			// a reload cancels a pending expiry
			st_next.busy = 1'b1;
			st_next.cnt = count;
		end else if (st_reg.busy) begin
			if (st_reg.cnt <= CNT_W'(1)) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy = st_reg.busy;
	assign done = st_reg.done;
endmodule
`default_nettype wire

// ==== rtl/rcs_ahb_slave.sv ====
// Purpose: AHB-Lite slave front end with one wait state
// Assumes: single word transfers only
// Notes: addresses with haddr[31:8] nonzero or misaligned decode to ADDR_NONE
`timescale 1ns/1ps
`default_nettype none
module rcs_ahb_slave (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// register side
	output logic             wr_stb,
	output logic [7:0]       rw_addr,
	output logic [31:0]      wr_data,
	input  wire logic [31:0] rd_data
);
	import rcs_pkg::*;

	rcs_bus_t st_reg;
	rcs_bus_t st_next;

	always_comb begin
		st_next = st_reg;
		if (st_reg.pend) begin
			// wait state gives read data a register stage
			st_next.pend = 1'b0;
			st_next.ready = 1'b1;
			if (!st_reg.write) begin
				st_next.rdata = rd_data;
			end
		end else if (hsel && htrans[1] && hready) begin
			st_next.pend = 1'b1;
			st_next.ready = 1'b0;
			st_next.write = hwrite;
			st_next.addr = (haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0) ?
				haddr[7:0] : ADDR_NONE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '{pend: 1'b0, write: 1'b0, addr: ADDR_NONE, ready: 1'b1,
				resp: 1'b0, rdata: 32'h00000000};
		end else begin
			st_reg <= st_next;
		end
	end

	assign hrdata = st_reg.rdata;
	assign hreadyout = st_reg.ready;
	assign hresp = st_reg.resp;
	assign wr_stb = st_reg.pend && st_reg.write;
	assign rw_addr = st_reg.addr;
	assign wr_data = hwdata;
endmodule
`default_nettype wire

// ==== rtl/rcs_reset_cause.sv ====
// Purpose: reset cause flags, start-up delays and reset values of core registers
// Assumes: event inputs are one-cycle pulses synchronous to hclk
// Notes: hresetn acts as a power-on reset and runs the full start-up delay
// Functional notes
// - brown-out flag is bit 0; a brown-out reset clears it
// - with brown-out reset disabled the brown-out flag carries no meaning
// - power-on flag in bit 1, cleared only by power-on; software sets it
// - crystal: power-up timer plus 1024 periods if enable low, else 1024
// - rc modes: power-up timer if enabled, otherwise CPU start-up delay
// - CPU start-up delay always follows power-on, brown-out and wake-up
// - power-on sets time-out and power-down flags to one
// - time-out and power-down flags encode which reset or wake-up occurred
// - every reset loads PC with zero; wake-up continues at PC plus one
// - interrupt wake-up with global enable set loads vector 0004h
// - status register takes the tabled value for each reset kind
// - flags read 10x after power-on, 1u0 after brown-out, else unchanged
// - resets force interrupt control bits 7:1 and the option register; wake-ups do not
// - oscillator start-up count begins when the power-up timer expires
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause #(
	parameter logic [rcs_pkg::CNT_W-1:0] PWRT_CYCLES = rcs_pkg::PWRT_CNT
) (
	// clock and reset
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	// ahb-lite
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic [31:0]                   hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	// reset and wake sources
	input  wire rcs_pkg::rcs_evt_t        evt,
	input  wire logic                     master_clear_pin_n,
	input  wire logic [rcs_pkg::PC_W-1:0] pc_now,
	// cpu control
	output var rcs_pkg::rcs_cpu_t         cpu
);
	import rcs_pkg::*;

	// ************************************************************
	// state and wiring
	// ************************************************************
	rcs_top_t         st_reg;
	rcs_top_t         st_next;
	logic             wr_stb;
	logic [7:0]       rw_addr;
	logic [31:0]      wr_data;
	logic [31:0]      rd_data;
	logic             t_load;
	logic [CNT_W-1:0] t_cnt;
	logic             t_busy;
	logic             t_done;
	logic             restart;
	logic             bor_en;
	logic             put_en_n;
	rcs_osc_t         osc;

	assign bor_en  = st_reg.cfg[CFG_BOREN];
	assign put_en_n = st_reg.cfg[CFG_PUT_EN_N];
	assign osc     = rcs_osc_t'(st_reg.cfg[CFG_OSC_LSB +: 2]);

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic rcs_seq_t power_seq(logic en_n, rcs_osc_t o);
		if (!en_n && (o == OSC_XTAL || o == OSC_RC)) begin
			return SEQ_PWRT;
		end
		if (o == OSC_XTAL) begin
			return SEQ_XST;
		end
		return SEQ_CPU;
	endfunction

	function automatic rcs_seq_t wake_seq(rcs_osc_t o);
		return (o == OSC_XTAL) ? SEQ_XST : SEQ_CPU;
	endfunction

	function automatic rcs_seq_t after_delay(rcs_seq_t s, rcs_osc_t o);
		if (s == SEQ_PWRT && o == OSC_XTAL) begin
			return SEQ_XST;
		end
		if (s == SEQ_PWRT || s == SEQ_XST) begin
			return SEQ_CPU;
		end
		return SEQ_RUN;
	endfunction

	function automatic logic [CNT_W-1:0] delay_cnt(rcs_seq_t s);
		if (s == SEQ_PWRT) begin
			return PWRT_CYCLES;
		end
		return (s == SEQ_XST) ? XST_CNT : CPU_CNT;
	endfunction

	function automatic logic is_reset(rcs_kind_t k);
		return k != KIND_WAKE_WDT && k != KIND_WAKE_IRQ;
	endfunction

	function automatic rcs_top_t hw_reset(rcs_top_t s, rcs_kind_t k);
		rcs_top_t r;
		r = s;
		r.kind = k;
		unique case (k)
			KIND_POR: begin
				r.flags[FLG_POR] = 1'b0;
				r.flags[FLG_AUX] = 1'b1;
				r.status[7:3] = ST_HI_PWR;
			end
			KIND_BOR: begin
				r.flags[FLG_BOR] = 1'b0;
				r.flags[FLG_AUX] = 1'b1;
				r.status[7:3] = ST_HI_PWR;
			end
			KIND_PIN: r.status[7:5] = ST_BANK_RST;
			KIND_PIN_SLP: r.status[7:3] = ST_HI_MSLP;
			KIND_WDT: r.status[7:3] = ST_HI_WDT;
			KIND_WAKE_WDT: begin
				r.status[STATUS_TMO] = 1'b0;
				r.status[STATUS_PWRDN] = 1'b0;
			end
			KIND_WAKE_IRQ: begin
				r.status[STATUS_TMO] = 1'b1;
				r.status[STATUS_PWRDN] = 1'b0;
			end
		endcase
		if (is_reset(k)) begin
			r.irqctl[7:1] = IRQCTL_H_RST;
			r.option = OPTION_RST;
		end
		return r;
	endfunction

	function automatic logic [PC_W-1:0] pc_for(rcs_kind_t k, logic global_irq_enable,
		logic [PC_W-1:0] pc);
		if (k == KIND_WAKE_IRQ && global_irq_enable) begin
			return PC_IRQ_VEC;
		end
		if (!is_reset(k)) begin
			return pc + PC_W'(1);
		end
		return PC_RESET;
	endfunction

	// ************************************************************
	// bus and timer
	// ************************************************************
	rcs_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_stb    (wr_stb),
		.rw_addr   (rw_addr),
		.wr_data   (wr_data),
		.rd_data   (rd_data)
	);

	rcs_delay_timer u_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (t_load),
		.count   (t_cnt),
		.busy    (t_busy),
		.done    (t_done)
	);

	// reads see the block's own state; unmapped reads are zero
	always_comb begin
		rd_data = 32'h00000000;
		case (rw_addr)
			ADDR_FLAGS: rd_data[2:0] = st_reg.flags;
			ADDR_STATUS: rd_data[7:0] = st_reg.status;
			ADDR_IRQCTL: rd_data[7:0] = st_reg.irqctl;
			ADDR_OPTION: rd_data[7:0] = st_reg.option;
			ADDR_CFG: rd_data[7:0] = st_reg.cfg;
			ADDR_SEQ: rd_data[7:0] = {t_busy, st_reg.kind, 1'b0, st_reg.seq};
			default: rd_data = 32'h00000000;
		endcase
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		restart = 1'b0;
		st_next.cpu.pc_load = 1'b0;
		st_next.pin_low = !master_clear_pin_n;
		// software first, so a reset in the same cycle overrides it
		if (wr_stb) begin
			case (rw_addr)
				ADDR_FLAGS: st_next.flags = st_reg.flags | wr_data[2:0];
				ADDR_STATUS: begin
					st_next.status[7:5] = wr_data[7:5];
					st_next.status[2:0] = wr_data[2:0];
				end
				ADDR_IRQCTL: st_next.irqctl = wr_data[7:0];
				ADDR_OPTION: st_next.option = wr_data[7:0];
				ADDR_CFG: st_next.cfg = wr_data[7:0];
				default: st_next.cfg = st_reg.cfg;
			endcase
		end
		if (evt.por || st_reg.seq == SEQ_BOOT) begin
			st_next = hw_reset(st_next, KIND_POR);
			st_next.seq = power_seq(put_en_n, osc);
			restart = 1'b1;
		end else if (evt.bor && bor_en) begin
			st_next = hw_reset(st_next, KIND_BOR);
			st_next.seq = power_seq(put_en_n, osc);
			restart = 1'b1;
		end else if (st_next.pin_low && !st_reg.pin_low) begin
			// during a start-up delay the delay keeps running
			if (st_reg.seq == SEQ_SLEEP) begin
				st_next = hw_reset(st_next, KIND_PIN_SLP);
				st_next.seq = SEQ_REL;
			end else if (st_reg.seq == SEQ_RUN || st_reg.seq == SEQ_REL) begin
				st_next = hw_reset(st_next, KIND_PIN);
				st_next.seq = SEQ_REL;
			end
		end else begin
			unique case (st_reg.seq)
				SEQ_PWRT, SEQ_XST, SEQ_CPU: begin
					if (t_done) begin
						st_next.seq = after_delay(st_reg.seq, osc);
					end
				end
				SEQ_REL: st_next.seq = SEQ_RUN;
				SEQ_RUN: begin
					if (evt.wdt) begin
						st_next = hw_reset(st_next, KIND_WDT);
						st_next.seq = SEQ_REL;
					end else if (evt.sleep && !st_reg.pin_low) begin
						st_next.seq = SEQ_SLEEP;
						st_next.status[STATUS_TMO] = 1'b1;
						st_next.status[STATUS_PWRDN] = 1'b0;
					end
				end
				SEQ_SLEEP: begin
					if (evt.wdt || evt.irq_wake) begin
						st_next = hw_reset(st_next,
							evt.wdt ? KIND_WAKE_WDT : KIND_WAKE_IRQ);
						st_next.seq = wake_seq(osc);
					end
				end
				SEQ_BOOT: st_next.seq = SEQ_BOOT;
			endcase
		end
		t_load = (st_next.seq == SEQ_PWRT || st_next.seq == SEQ_XST ||
			st_next.seq == SEQ_CPU) && (restart || st_next.seq != st_reg.seq);
		t_cnt = delay_cnt(st_next.seq);
		// the pin holds the core even after all delays have expired
		st_next.cpu.hold = st_next.seq != SEQ_RUN || st_next.pin_low;
		if (st_reg.cpu.hold && !st_next.cpu.hold) begin
			st_next.cpu.pc_load = 1'b1;
			st_next.cpu.pc_value = pc_for(st_next.kind,
				st_next.irqctl[IRQCTL_GLB_EN], pc_now);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '{seq: SEQ_BOOT, kind: KIND_POR, pin_low: 1'b0,
				flags: FLG_RST, status: STATUS_RST, irqctl: IRQCTL_RST,
				option: OPTION_RST, cfg: CFG_RST,
				cpu: '{hold: 1'b1, pc_load: 1'b0, pc_value: PC_RESET}};
		end else begin
			st_reg <= st_next;
		end
	end

	assign cpu = st_reg.cpu;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_enter_xst;
		st_reg.seq == SEQ_XST && $past(st_reg.seq) != SEQ_XST;
	endsequence
	sequence s_enter_cpu;
		st_reg.seq == SEQ_CPU && $past(st_reg.seq) != SEQ_CPU;
	endsequence

	property p_por_flags;
		evt.por |=> st_reg.status[STATUS_TMO] && st_reg.status[STATUS_PWRDN];
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("por left flags low");

	property p_por_flg;
		evt.por |=> !st_reg.flags[FLG_POR] && st_reg.flags[FLG_AUX];
	endproperty
	a_por_flg: assert property (p_por_flg) else $error("por flag not cleared");

	property p_bor_flg;
		evt.bor && bor_en && !evt.por && !wr_stb && st_reg.seq != SEQ_BOOT
			|=> !st_reg.flags[FLG_BOR] && st_reg.flags[FLG_POR] == $past(st_reg.flags[FLG_POR]);
	endproperty
	a_bor_flg: assert property (p_bor_flg) else $error("bor flags wrong");

	property p_bor_off;
		evt.bor && !bor_en && !evt.por && !wr_stb && st_reg.seq == SEQ_RUN
			|=> $stable(st_reg.flags);
	endproperty
	a_bor_off: assert property (p_bor_off) else $error("disabled bor acted");

	property p_sw_set;
		wr_stb && rw_addr == ADDR_FLAGS && wr_data[FLG_BOR] && !evt.bor
			|=> st_reg.flags[FLG_BOR];
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("flag set lost");

	property p_xst_load;
		s_enter_xst |-> $past(t_load) && $past(t_cnt) == XST_CNT;
	endproperty
	a_xst_load: assert property (p_xst_load) else $error("crystal count wrong");

	property p_cpu_load;
		s_enter_cpu |-> $past(t_cnt) == CPU_CNT ##1 t_busy [*8];
	endproperty
	a_cpu_load: assert property (p_cpu_load) else $error("cpu delay wrong");

	property p_xtal_pwrt;
		evt.por && osc == OSC_XTAL && !put_en_n |=> st_reg.seq == SEQ_PWRT;
	endproperty
	a_xtal_pwrt: assert property (p_xtal_pwrt) else $error("power-up timer skipped");

	property p_rc_nopwrt;
		evt.por && osc == OSC_RC && put_en_n |=> st_reg.seq == SEQ_CPU;
	endproperty
	a_rc_nopwrt: assert property (p_rc_nopwrt) else $error("rc delay wrong");

	property p_pc_reset;
		cpu.pc_load && is_reset(st_reg.kind) |-> cpu.pc_value == PC_RESET;
	endproperty
	a_pc_reset: assert property (p_pc_reset) else $error("reset pc not zero");

	property p_irq_vec;
		cpu.pc_load && st_reg.kind == KIND_WAKE_IRQ && st_reg.irqctl[IRQCTL_GLB_EN]
			|-> cpu.pc_value == PC_IRQ_VEC;
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("irq vector wrong");

	property p_wdt_wake;
		st_reg.seq == SEQ_SLEEP && evt.wdt && !evt.por && !(evt.bor && bor_en)
			&& !st_next.pin_low |=> st_reg.status[4:3] == 2'b00 && $stable(st_reg.option);
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("wake status wrong");

	property p_sfr_reset;
		st_reg.seq == SEQ_RUN && evt.wdt && !evt.por && !st_next.pin_low
			|=> st_reg.option == OPTION_RST && st_reg.irqctl[7:1] == IRQCTL_H_RST;
	endproperty
	a_sfr_reset: assert property (p_sfr_reset) else $error("sfr not reset");
endmodule
`default_nettype wire

// ==== verification/reset_cause_and_startup_timeout_test.sv ====
// Purpose: self-checking bench of the reset cause and start-up delay block
// Assumes: power-up timer shortened to 8 cycles; one oscillator period is one hclk period
// Notes: delay checks allow a few cycles of slack for the release handshake
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_startup_timeout_test;
	import rcs_pkg::*;
	// ************************************************************
	// design and stimulus
	// ************************************************************
	localparam int P = 8;
	localparam int O = XST_PERIODS;
	localparam int C = CPU_START_CYC;
	logic            hclk;
	logic            hresetn;
	logic            hsel;
	logic [31:0]     haddr;
	logic [1:0]      htrans;
	logic            hwrite;
	logic [31:0]     hwdata;
	logic [31:0]     hrdata;
	logic            hreadyout;
	logic            hresp;
	rcs_evt_t        evt;
	logic            pin_n;
	logic [PC_W-1:0] pc_now;
	rcs_cpu_t        cpu;
	int              n_errors;
	int              num_checks;
	rcs_reset_cause #(.PWRT_CYCLES(16'h0008)) u_rcs_reset_cause (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .evt(evt),
		.master_clear_pin_n(pin_n), .pc_now(pc_now), .cpu(cpu)
	);
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// waits for hready with a bound; a hang ends the run
	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 100);
		if (i >= 100) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= w;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] rd;
		ahb(1'b1, a, {24'h0, d}, rd);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] rd;
		ahb(1'b0, a, 32'h0, rd);
		check(rd, {24'h0, exp});
		check({31'h0, hresp}, 32'h0);
	endtask
	task automatic fire(input rcs_evt_t e);
		@(posedge hclk);
		evt <= e;
		@(posedge hclk);
		evt <= '0;
	endtask
	// counts cycles until the core is released, then checks the start address
	task automatic wait_load(input int exp, input logic [PC_W-1:0] pc);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			#1;
			n++;
		end while (cpu.pc_load !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			n_errors++;
			conclude();
		end
		check({19'h0, cpu.pc_value}, {19'h0, pc});
		check({31'h0, cpu.hold}, 32'h0);
		check({31'h0, (n >= exp && n <= exp + 4)}, 32'h1);
	endtask
	task automatic pin_pulse();
		@(posedge hclk);
		pin_n <= 1'b0;
		repeat (4) @(posedge hclk);
		pin_n <= 1'b1;
		wait_load(0, 13'h0000);
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		logic [7:0] cfg_tab [4];
		int         exp_tab [4];
		cfg_tab = '{8'h03, 8'h06, 8'h07, 8'h0b};
		exp_tab = '{O + C, P + C, C, C};
		n_errors = 0;
		num_checks = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		evt = '0;
		pin_n = 1'b1;
		pc_now = 13'h0123;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		wait_load(P + O + C, 13'h0000);
		rd_chk(ADDR_FLAGS, 8'h04);
		rd_chk(ADDR_STATUS, 8'h18);
		rd_chk(ADDR_IRQCTL, 8'h00);
		rd_chk(ADDR_OPTION, 8'hff);
		rd_chk(8'h40, 8'h00);
		wr(ADDR_FLAGS, 8'h00);
		rd_chk(ADDR_FLAGS, 8'h04);
		wr(ADDR_FLAGS, 8'h03);
		rd_chk(ADDR_FLAGS, 8'h07);
		// brown-out with its reset disabled leaves the flags alone
		fire(5'h08);
		rd_chk(ADDR_FLAGS, 8'h07);
		wr(ADDR_CFG, 8'h02);
		wr(ADDR_IRQCTL, 8'h80);
		wr(ADDR_OPTION, 8'h00);
		fire(5'h08);
		wait_load(P + O + C, 13'h0000);
		rd_chk(ADDR_FLAGS, 8'h06);
		rd_chk(ADDR_STATUS, 8'h18);
		rd_chk(ADDR_IRQCTL, 8'h00);
		rd_chk(ADDR_OPTION, 8'hff);
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CFG, cfg_tab[k]);
			fire(5'h08);
			wait_load(exp_tab[k], 13'h0000);
		end
		wr(ADDR_STATUS, 8'h05);
		wr(ADDR_IRQCTL, 8'h80);
		wr(ADDR_OPTION, 8'h5a);
		fire(5'h04);
		wait_load(0, 13'h0000);
		rd_chk(ADDR_STATUS, 8'h0d);
		rd_chk(ADDR_IRQCTL, 8'h00);
		rd_chk(ADDR_OPTION, 8'hff);
		rd_chk(ADDR_FLAGS, 8'h06);
		wr(ADDR_IRQCTL, 8'h80);
		fire(5'h01);
		rd_chk(ADDR_STATUS, 8'h15);
		fire(5'h04);
		wait_load(C, 13'h0124);
		rd_chk(ADDR_STATUS, 8'h05);
		rd_chk(ADDR_IRQCTL, 8'h80);
		wr(ADDR_CFG, 8'h02);
		fire(5'h01);
		fire(5'h02);
		wait_load(O + C, 13'h0004);
		rd_chk(ADDR_STATUS, 8'h15);
		wr(ADDR_IRQCTL, 8'h00);
		fire(5'h01);
		fire(5'h02);
		wait_load(O + C, 13'h0124);
		fire(5'h01);
		pin_pulse();
		rd_chk(ADDR_STATUS, 8'h15);
		rd_chk(ADDR_FLAGS, 8'h06);
		wr(ADDR_STATUS, 8'he2);
		pin_pulse();
		rd_chk(ADDR_STATUS, 8'h12);
		fire(5'h10);
		wait_load(P + O + C, 13'h0000);
		rd_chk(ADDR_FLAGS, 8'h04);
		rd_chk(ADDR_STATUS, 8'h1a);
		conclude();
	end
endmodule
`default_nettype wire
